// file: verilog/pam_monitor.sv
// Purpose: primary activity monitor with apb register slave
// Assumes: all inputs synchronous to pclk; one i/o cycle per valid
// Notes:   apb answers with pready on the first access cycle
//
// What this block does
// - keyboard port 60h access sets bit 7
// - four serial ranges set bit 6
// - two parallel ranges set bit 5
// - enabled primary interrupt sets bit 1
// - isa master or dma sets bit 0
// - status set by hardware, write one clears
// - status pairs with enable; reserved bits zero
// - enabled newly set status sets global flag
// - global flag requests smi, reloads first timer
// - status bits 7,6,4,3 reload second timer
// - reload enables at 7,6,4,3,0; others zero
// - reload bit 0 reloads first timer
// - reload enables reset to zero
// - global smi enable gates every smi
// - eight-bit smi command register
// - smi command write sets software smi flag
`timescale 1ns/1ps
module pam_monitor
  import pam_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire pam_io_access_s       io_access,
  input  wire logic [15:0]          pirq_lines,
  input  wire logic [15:0]          pirq_primary_en,
  input  wire logic                 bus_master_active,
  input  wire logic                 dma_active,
  output logic                      irq,
  output logic                      smi_req,
  output logic                      first_timer_reload,
  output logic                      second_timer_reload
);

  // byte addresses
  localparam logic [ADDR_W-1:0] A_SOFTWARE_SMI_COMMAND   = {IDX_SOFTWARE_SMI_COMMAND, 2'b00};
  localparam logic [ADDR_W-1:0] A_ACT_STS   = {IDX_ACT_STS, 2'b00};
  localparam logic [ADDR_W-1:0] A_ACT_EN    = {IDX_ACT_EN, 2'b00};
  localparam logic [ADDR_W-1:0] A_RELOAD_EN = {IDX_RELOAD_EN, 2'b00};
  localparam logic [ADDR_W-1:0] A_GBL_STS   = {IDX_GBL_STS, 2'b00};
  localparam logic [ADDR_W-1:0] A_GBL_CTL   = {IDX_GBL_CTL, 2'b00};
  localparam logic [ADDR_W-1:0] A_IRQ_STS   = {IDX_IRQ_STS, 2'b00};
  localparam logic [ADDR_W-1:0] A_IRQ_MASK  = {IDX_IRQ_MASK, 2'b00};

  pam_phase_e       phase_reg;
  logic [7:0]       software_smi_command_reg;
  logic [7:0]       act_sts_reg;
  logic [7:0]       act_en_reg;
  logic [7:0]       reload_en_reg;
  logic [1:0]       gbl_sts_reg;
  logic [2:0]       gbl_ctl_reg;
  logic [3:0]       irq_sts_reg;
  logic [3:0]       irq_mask_reg;
  logic [15:0]      pirq_prev_reg;
  logic [31:0]      rd_next;
  logic             map_hit;
  logic             setup;
  logic             done;
  logic             wr_done;
  logic             rd_done;
  logic [7:0]       det;
  logic [7:0]       act_clr;
  logic [7:0]       act_rise;
  logic             gact_set;
  logic             gact_rise;
  logic             sw_set;
  logic             t1_fire;
  logic             t2_fire;
  logic             smi_next;
  logic [15:0]      a;

  // ---------------- i/o range decode ----------------
  assign a = io_access.addr;

  always_comb begin
    det = 8'h00;
    det[BIT_KBD] = io_access.valid && (a == IO_KBD);
    det[BIT_SER] = io_access.valid &&
                   (((a & IO_BLK8) == IO_COM1) ||
                    ((a & IO_BLK8) == IO_COM2) ||
                    ((a & IO_BLK8) == IO_COM3) ||
                    ((a & IO_BLK8) == IO_COM4));
    det[BIT_PAR] = io_access.valid &&
                   (((a & IO_BLK8) == IO_LPT1) ||
                    ((a & IO_BLK8) == IO_LPT2));
    det[BIT_VID] = io_access.valid &&
                   (a >= IO_VID_LO) && (a <= IO_VID_HI);
    det[BIT_DISK] = io_access.valid &&
                    (((a & IO_BLK8) == IO_IDE1) ||
                     ((a & IO_BLK8) == IO_IDE2) ||
                     (a == IO_IDE2_CT) ||
                     ((a & IO_BLK8) == IO_FDC));
    // only a rising request on a primary channel counts
    det[BIT_PIRQ] = |(pirq_lines & ~pirq_prev_reg &
                      pirq_primary_en);
    det[BIT_DMA] = bus_master_active || dma_active;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pirq_prev_reg <= 16'h0000;
    end else begin
      pirq_prev_reg <= pirq_lines;
    end
  end

  // ---------------- apb slave ----------------
  assign setup   = psel && !penable && (phase_reg == PH_IDLE);
  assign done    = psel && penable && pready;
  assign wr_done = done && pwrite && !pslverr;
  assign rd_done = done && !pwrite && !pslverr;

  always_comb begin
    rd_next = 32'h0000_0000;
    map_hit = 1'b1;
    case (paddr)
      A_SOFTWARE_SMI_COMMAND:   rd_next[7:0] = software_smi_command_reg;
      A_ACT_STS:   rd_next[7:0] = act_sts_reg & ACT_MASK;
      A_ACT_EN:    rd_next[7:0] = act_en_reg & ACT_MASK;
      A_RELOAD_EN: rd_next[7:0] = reload_en_reg & RELOAD_MASK;
      A_GBL_STS:   rd_next[1:0] = gbl_sts_reg;
      A_GBL_CTL:   rd_next[2:0] = gbl_ctl_reg;
      A_IRQ_STS:   rd_next[3:0] = irq_sts_reg;
      A_IRQ_MASK:  rd_next[3:0] = irq_mask_reg;
      default:     map_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= PH_IDLE;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h0000_0000;
    end else begin
      case (phase_reg)
        PH_IDLE: begin
          if (setup) begin
            phase_reg <= PH_ACCESS;
            pready    <= 1'b1;
            pslverr   <= !map_hit;
            prdata    <= pwrite ? 32'h0000_0000 : rd_next;
          end
        end
        PH_ACCESS: begin
          phase_reg <= PH_IDLE;
          pready    <= 1'b0;
          pslverr   <= 1'b0;
          prdata    <= 32'h0000_0000;
        end
        default: begin
          phase_reg <= PH_IDLE;
          pready    <= 1'b0;
          pslverr   <= 1'b0;
        end
      endcase
    end
  end

  // ---------------- software registers ----------------
  assign sw_set = wr_done && (paddr == A_SOFTWARE_SMI_COMMAND) && pstrb[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      software_smi_command_reg <= RST_SOFTWARE_SMI_COMMAND;
    end else if (sw_set) begin
      software_smi_command_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_en_reg    <= RST_REG8;
      reload_en_reg <= RST_REG8;
      gbl_ctl_reg   <= 3'b000;
      irq_mask_reg  <= RST_REG4;
    end else if (wr_done && pstrb[0]) begin
      if (paddr == A_ACT_EN) begin
        act_en_reg <= pwdata[7:0] & ACT_MASK;
      end
      if (paddr == A_RELOAD_EN) begin
        reload_en_reg <= pwdata[7:0] & RELOAD_MASK;
      end
      if (paddr == A_GBL_CTL) begin
        gbl_ctl_reg <= pwdata[2:0];
      end
      if (paddr == A_IRQ_MASK) begin
        irq_mask_reg <= pwdata[3:0];
      end
    end
  end

  // ---------------- activity status, one flop per bit ----------------
  assign act_clr = (wr_done && (paddr == A_ACT_STS) && pstrb[0]) ?
                   pwdata[7:0] : 8'h00;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_act
      if (ACT_MASK[gi]) begin : g_used
        // a bit cleared in the same cycle it is hit counts as a new rise
        assign act_rise[gi] = det[gi] &&
                              (!act_sts_reg[gi] || act_clr[gi]);
        always_ff @(posedge pclk or negedge presetn) begin
          if (!presetn) begin
            act_sts_reg[gi] <= 1'b0;
          end else if (det[gi]) begin
            act_sts_reg[gi] <= 1'b1;
          end else if (act_clr[gi]) begin
            act_sts_reg[gi] <= 1'b0;
          end
        end
      end else begin : g_rsvd
        assign act_rise[gi] = 1'b0;
        always_ff @(posedge pclk or negedge presetn) begin
          if (!presetn) begin
            act_sts_reg[gi] <= 1'b0;
          end else begin
            act_sts_reg[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ---------------- global flags and smi ----------------
  assign gact_set  = |(act_rise & act_en_reg);
  assign gact_rise = gact_set && !gbl_sts_reg[GS_ACT];
  assign t1_fire   = gact_rise && reload_en_reg[0];
  assign t2_fire   = |(act_rise & reload_en_reg & T2_SRC_MASK);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gbl_sts_reg <= 2'b00;
    end else begin
      if (gact_set) begin
        gbl_sts_reg[GS_ACT] <= 1'b1;
      end else if (wr_done && (paddr == A_GBL_STS) && pstrb[0] &&
                   pwdata[GS_ACT]) begin
        gbl_sts_reg[GS_ACT] <= 1'b0;
      end
      if (sw_set) begin
        gbl_sts_reg[GS_SWSMI] <= 1'b1;
      end else if (wr_done && (paddr == A_GBL_STS) && pstrb[0] &&
                   pwdata[GS_SWSMI]) begin
        gbl_sts_reg[GS_SWSMI] <= 1'b0;
      end
    end
  end

  assign smi_next = gbl_ctl_reg[GC_SMI] &&
                    ((gbl_sts_reg[GS_ACT] && gbl_ctl_reg[GC_ACT]) ||
                     (gbl_sts_reg[GS_SWSMI] &&
                      gbl_ctl_reg[GC_SWSMI]));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smi_req             <= 1'b0;
      first_timer_reload  <= 1'b0;
      second_timer_reload <= 1'b0;
    end else begin
      smi_req             <= smi_next;
      first_timer_reload  <= t1_fire;
      second_timer_reload <= t2_fire;
    end
  end

  // ---------------- interrupt status ----------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts_reg <= RST_REG4;
    end else begin
      // a read clears only the bits it returned; new events still win
      irq_sts_reg <= ((rd_done && (paddr == A_IRQ_STS)) ?
                      (irq_sts_reg & ~prdata[3:0]) : irq_sts_reg) |
                     {t2_fire, t1_fire, sw_set, gact_rise};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_sts_reg & irq_mask_reg);
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_status_write(int unsigned b);
    wr_done && (paddr == A_ACT_STS) && pstrb[0] && pwdata[b];
  endsequence

  sequence s_status_read_back;
    ##1 (act_sts_reg[BIT_KBD] == 1'b0);
  endsequence

  property p_kbd;
    io_access.valid && (io_access.addr == IO_KBD)
      |=> act_sts_reg[BIT_KBD];
  endproperty
  a_kbd: assert property (p_kbd)
    else $error("keyboard access did not set status");

  property p_ser;
    io_access.valid && ((io_access.addr & IO_BLK8) == IO_COM4)
      |=> act_sts_reg[BIT_SER];
  endproperty
  a_ser: assert property (p_ser)
    else $error("serial access did not set status");

  property p_par;
    io_access.valid && ((io_access.addr & IO_BLK8) == IO_LPT2)
      |=> act_sts_reg[BIT_PAR];
  endproperty
  a_par: assert property (p_par)
    else $error("parallel access did not set status");

  property p_pirq;
    |(pirq_lines & ~pirq_prev_reg & pirq_primary_en)
      |=> act_sts_reg[BIT_PIRQ];
  endproperty
  a_pirq: assert property (p_pirq)
    else $error("primary interrupt did not set status");

  property p_dma;
    (bus_master_active || dma_active) |=> act_sts_reg[BIT_DMA];
  endproperty
  a_dma: assert property (p_dma)
    else $error("master or dma activity did not set status");

  property p_vid;
    io_access.valid && (io_access.addr >= IO_VID_LO) &&
      (io_access.addr <= IO_VID_HI) |=> act_sts_reg[BIT_VID];
  endproperty
  a_vid: assert property (p_vid)
    else $error("video access did not set status");

  property p_w1c;
    s_status_write(BIT_KBD) and !det[BIT_KBD] |-> s_status_read_back;
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write one did not clear status");

  property p_hold;
    !det[BIT_SER] && !act_clr[BIT_SER] |=>
      $stable(act_sts_reg[BIT_SER]);
  endproperty
  a_hold: assert property (p_hold)
    else $error("status changed without cause");

  property p_rsvd;
    ((act_sts_reg | act_en_reg) & ~ACT_MASK) == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved activity bit set");

  property p_gact;
    |(act_rise & act_en_reg) |=> gbl_sts_reg[GS_ACT];
  endproperty
  a_gact: assert property (p_gact)
    else $error("enabled activity did not set global flag");

  property p_smi;
    gbl_sts_reg[GS_ACT] && gbl_ctl_reg[GC_ACT] && gbl_ctl_reg[GC_SMI]
      |=> smi_req;
  endproperty
  a_smi: assert property (p_smi)
    else $error("global activity did not request smi");

  property p_t2;
    |(act_rise & reload_en_reg & T2_SRC_MASK) |=> second_timer_reload;
  endproperty
  a_t2: assert property (p_t2)
    else $error("second timer not reloaded");

  property p_reload_rsvd;
    (reload_en_reg & ~RELOAD_MASK) == 8'h00;
  endproperty
  a_reload_rsvd: assert property (p_reload_rsvd)
    else $error("reserved reload bit set");

  property p_t1;
    first_timer_reload |-> $past(reload_en_reg[0]) &&
                           !$past(gbl_sts_reg[GS_ACT]) &&
                           gbl_sts_reg[GS_ACT];
  endproperty
  a_t1: assert property (p_t1)
    else $error("first timer reload without cause");

  property p_noreload;
    (reload_en_reg == 8'h00) |=> !first_timer_reload &&
                                 !second_timer_reload;
  endproperty
  a_noreload: assert property (p_noreload)
    else $error("reload while all reload enables clear");

  property p_smi_gate;
    !gbl_ctl_reg[GC_SMI] |=> !smi_req;
  endproperty
  a_smi_gate: assert property (p_smi_gate)
    else $error("smi requested while disabled");

  property p_cmd;
    sw_set |=> (software_smi_command_reg == $past(pwdata[7:0])) &&
               gbl_sts_reg[GS_SWSMI];
  endproperty
  a_cmd: assert property (p_cmd)
    else $error("smi command write not stored");

  property p_pulse;
    first_timer_reload |=> !first_timer_reload;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("first timer reload longer than one cycle");

endmodule

// file: verilog/pam_pkg.sv
// Purpose: constants and carriers for the primary activity monitor
// Assumes: register index times four gives the apb byte address
// Notes:   io ranges are compared on 16-bit i/o addresses
package pam_pkg;
  localparam int unsigned ADDR_W = 10;
  // register indices
  localparam logic [7:0] IDX_SOFTWARE_SMI_COMMAND   = 8'h2f;
  localparam logic [7:0] IDX_ACT_STS   = 8'h30;
  localparam logic [7:0] IDX_ACT_EN    = 8'h34;
  localparam logic [7:0] IDX_RELOAD_EN = 8'h38;
  localparam logic [7:0] IDX_GBL_STS   = 8'h3c;
  localparam logic [7:0] IDX_GBL_CTL   = 8'h3d;
  localparam logic [7:0] IDX_IRQ_STS   = 8'h3e;
  localparam logic [7:0] IDX_IRQ_MASK  = 8'h3f;
  // activity bit positions
  localparam int unsigned BIT_KBD  = 7;
  localparam int unsigned BIT_SER  = 6;
  localparam int unsigned BIT_PAR  = 5;
  localparam int unsigned BIT_VID  = 4;
  localparam int unsigned BIT_DISK = 3;
  localparam int unsigned BIT_PIRQ = 1;
  localparam int unsigned BIT_DMA  = 0;
  localparam logic [7:0] ACT_MASK    = 8'hfb;
  localparam logic [7:0] RELOAD_MASK = 8'hd9;
  localparam logic [7:0] T2_SRC_MASK = 8'hd8;
  // global status / control / irq bit positions
  localparam int unsigned GS_ACT   = 0;
  localparam int unsigned GS_SWSMI = 1;
  localparam int unsigned GC_SMI   = 0;
  localparam int unsigned GC_ACT   = 1;
  localparam int unsigned GC_SWSMI = 2;
  localparam int unsigned IRQ_ACT  = 0;
  localparam int unsigned IRQ_SW   = 1;
  localparam int unsigned IRQ_T1   = 2;
  localparam int unsigned IRQ_T2   = 3;
  // reset values
  localparam logic [7:0] RST_SOFTWARE_SMI_COMMAND = 8'h00;
  localparam logic [7:0] RST_REG8    = 8'h00;
  localparam logic [3:0] RST_REG4    = 4'h0;
  // i/o decode
  localparam logic [15:0] IO_KBD     = 16'h0060;
  localparam logic [15:0] IO_BLK8    = 16'hfff8;
  localparam logic [15:0] IO_COM1    = 16'h03f8;
  localparam logic [15:0] IO_COM2    = 16'h02f8;
  localparam logic [15:0] IO_COM3    = 16'h03e8;
  localparam logic [15:0] IO_COM4    = 16'h02e8;
  localparam logic [15:0] IO_LPT1    = 16'h0378;
  localparam logic [15:0] IO_LPT2    = 16'h0278;
  localparam logic [15:0] IO_VID_LO  = 16'h03b0;
  localparam logic [15:0] IO_VID_HI  = 16'h03df;
  localparam logic [15:0] IO_IDE1    = 16'h01f0;
  localparam logic [15:0] IO_IDE2    = 16'h0170;
  localparam logic [15:0] IO_IDE2_CT = 16'h0376;
  localparam logic [15:0] IO_FDC     = 16'h03f0;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } pam_io_access_s;

  typedef enum logic [1:0] {PH_IDLE, PH_ACCESS, PH_DONE} pam_phase_e;
endpackage

// file: tb/pam_act_model.sv
// Purpose: io, interrupt and dma activity source for the monitor
// Assumes: every change lands right after a pclk rising edge
// Notes:   a released io address is inverted so it never looks stale
`timescale 1ns/1ps
module pam_act_model
  import pam_pkg::*;
(
  input  wire logic      pclk,
  output pam_io_access_s io_access,
  output logic [15:0]    pirq_lines,
  output logic           bus_master_active,
  output logic           dma_active
);
  initial begin
    io_access = '0;
    pirq_lines = '0;
    bus_master_active = 1'b0;
    dma_active = 1'b0;
  end

  // one decoded i/o cycle, valid for a single clock
  task automatic io_cycle(input logic [15:0] a);
    @(posedge pclk);
    io_access <= '{valid: 1'b1, addr: a};
    @(posedge pclk);
    io_access <= '{valid: 1'b0, addr: ~a};
  endtask

  task automatic irq_edge(input int n);
    @(posedge pclk);
    pirq_lines[n] <= 1'b1;
    @(posedge pclk);
    pirq_lines[n] <= 1'b0;
  endtask

  task automatic dma_burst(input logic bm);
    @(posedge pclk);
    bus_master_active <= bm;
    dma_active <= !bm;
    @(posedge pclk);
    bus_master_active <= 1'b0;
    dma_active <= 1'b0;
  endtask
endmodule

// file: tb/testbench.sv
// Purpose: self-checking bench for the primary activity monitor
// Assumes: apb master on pclk, read results scored from a queue
// Notes:   pulse outputs are counted per high cycle
`timescale 1ns/1ps
module testbench;
  import pam_pkg::*;
  typedef struct packed {
    logic        err;
    logic [31:0] care;
    logic [31:0] data;
  } pam_tb_exp_s;

  logic              pclk, presetn, psel, penable, pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata;
  logic [3:0]        pstrb;
  logic              pready, pslverr, irq, smi_req;
  logic              first_timer_reload, second_timer_reload;
  logic [15:0]       pirq_lines, pirq_primary_en;
  logic              bus_master_active, dma_active;
  pam_io_access_s    io_access;
  pam_tb_exp_s       exp_q[$];
  int                error_cnt, samples_checked, ftr_cnt, str_cnt;
  logic [15:0] io_base [12] = '{16'h0060, 16'h03f8, 16'h02f8,
    16'h03e8, 16'h02e8, 16'h0378, 16'h0278, 16'h03b0, 16'h01f0,
    16'h0170, 16'h03f0, 16'h0280};
  int io_span [12] = '{1, 8, 8, 8, 8, 8, 8, 48, 8, 8, 8, 8};
  int io_bit [12] = '{7, 6, 6, 6, 6, 5, 5, 4, 3, 3, 3, -1};

  pam_monitor u_pam_monitor (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .io_access,
    .pirq_lines, .pirq_primary_en, .bus_master_active, .dma_active,
    .irq, .smi_req, .first_timer_reload, .second_timer_reload);
  pam_act_model u_pam_act_model (.pclk, .io_access, .pirq_lines,
    .bus_master_active, .dma_active);

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      chk("pready", 32'(pready), 32'h1);
      wrap_up();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] d,
                    input logic [31:0] care = 32'hffffffff,
                    input logic err = 1'b0);
    exp_q.push_back('{err: err, care: care, data: d});
    apb(1'b0, idx, 32'h0);
  endtask

  task automatic hold(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // scoreboard: every completed read takes the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
      if (exp_q.size() == 0) begin
        chk("read_note", 32'h1, 32'h0);
      end else begin
        chk("prdata", prdata & exp_q[0].care, exp_q[0].data);
        chk("pslverr", 32'(pslverr), 32'(exp_q[0].err));
        void'(exp_q.pop_front());
      end
    end
  end

  always @(posedge pclk) begin
    if (first_timer_reload === 1'b1) ftr_cnt <= ftr_cnt + 1;
    if (second_timer_reload === 1'b1) str_cnt <= str_cnt + 1;
  end

  initial begin
    repeat (30000) @(posedge pclk);
    chk("watchdog", 32'h1, 32'h0);
    wrap_up();
  end

  initial begin
    logic [15:0] a;
    logic [7:0]  d;
    int          c, k;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    pirq_primary_en = '0;
    void'($urandom(68431));
    hold(20);
    presetn <= 1'b1;
    rd(IDX_ACT_STS, 32'h0);
    rd(IDX_ACT_EN, 32'h0);
    rd(IDX_RELOAD_EN, 32'h0);
    rd(IDX_SOFTWARE_SMI_COMMAND, 32'h0);
    rd(8'h00, 32'h0, 32'hffffffff, 1'b1);
    wr(IDX_ACT_EN, 32'hffffffff);
    rd(IDX_ACT_EN, {24'h0, ACT_MASK});
    wr(IDX_RELOAD_EN, 32'hffffffff);
    rd(IDX_RELOAD_EN, {24'h0, RELOAD_MASK});
    wr(IDX_ACT_EN, 32'h0);
    wr(IDX_RELOAD_EN, 32'h0);
    d = 8'($urandom);
    wr(IDX_SOFTWARE_SMI_COMMAND, {24'h0, d});
    rd(IDX_SOFTWARE_SMI_COMMAND, {24'h0, d});
    pstrb <= 4'he;
    wr(IDX_SOFTWARE_SMI_COMMAND, {24'h0, ~d});
    pstrb <= 4'hf;
    rd(IDX_SOFTWARE_SMI_COMMAND, {24'h0, d});
    rd(IDX_GBL_STS, 32'h2, 32'h2);
    wr(IDX_GBL_STS, 32'h3);
    for (int i = 0; i < 12; i++) begin
      a = io_base[i] + 16'($urandom % io_span[i]);
      wr(IDX_ACT_STS, 32'hff);
      u_pam_act_model.io_cycle(a);
      rd(IDX_ACT_STS, io_bit[i] < 0 ? 32'h0 : 32'h1 << io_bit[i]);
    end
    u_pam_act_model.io_cycle(IO_KBD);
    wr(IDX_ACT_STS, 32'h0);
    rd(IDX_ACT_STS, 32'h80);
    wr(IDX_ACT_STS, 32'h80);
    rd(IDX_ACT_STS, 32'h0);
    k = $urandom % 16;
    pirq_primary_en <= (16'($urandom) | (16'h1 << k)) &
                       ~(16'h1 << (k ^ 1));
    u_pam_act_model.irq_edge(k ^ 1);
    rd(IDX_ACT_STS, 32'h0);
    u_pam_act_model.irq_edge(k);
    rd(IDX_ACT_STS, 32'h2);
    wr(IDX_ACT_STS, 32'h2);
    u_pam_act_model.dma_burst(1'b1);
    rd(IDX_ACT_STS, 32'h1);
    wr(IDX_ACT_STS, 32'h1);
    u_pam_act_model.dma_burst(1'b0);
    rd(IDX_ACT_STS, 32'h1);
    wr(IDX_ACT_STS, 32'h1);
    rd(IDX_ACT_STS, 32'h0);
    wr(IDX_RELOAD_EN, 32'h1);
    c = ftr_cnt;
    u_pam_act_model.io_cycle(IO_KBD);
    hold(4);
    rd(IDX_GBL_STS, 32'h0, 32'h1);
    chk("first_reload_cnt", 32'(ftr_cnt), 32'(c));
    wr(IDX_ACT_STS, 32'hff);
    wr(IDX_ACT_EN, 32'h80);
    wr(IDX_GBL_CTL, 32'h2);
    u_pam_act_model.io_cycle(IO_KBD);
    hold(4);
    chk("first_reload_cnt", 32'(ftr_cnt), 32'(c + 1));
    chk("smi_req", 32'(smi_req), 32'h0);
    rd(IDX_GBL_STS, 32'h1, 32'h1);
    wr(IDX_GBL_CTL, 32'h3);
    hold(4);
    chk("smi_req", 32'(smi_req), 32'h1);
    wr(IDX_GBL_CTL, 32'h0);
    wr(IDX_GBL_STS, 32'h3);
    wr(IDX_ACT_EN, 32'h0);
    wr(IDX_ACT_STS, 32'hff);
    wr(IDX_RELOAD_EN, 32'h80);
    c = str_cnt;
    u_pam_act_model.io_cycle(IO_KBD);
    u_pam_act_model.io_cycle(IO_COM1);
    hold(4);
    chk("second_reload_cnt", 32'(str_cnt), 32'(c + 1));
    wr(IDX_IRQ_MASK, 32'h2);
    rd(IDX_IRQ_STS, 32'h0, 32'h0);
    hold(3);
    chk("irq", 32'(irq), 32'h0);
    wr(IDX_SOFTWARE_SMI_COMMAND, 32'h5a);
    hold(3);
    chk("irq", 32'(irq), 32'h1);
    rd(IDX_IRQ_STS, 32'h2, 32'h2);
    hold(3);
    chk("irq", 32'(irq), 32'h0);
    wr(IDX_IRQ_MASK, 32'h0);
    wr(IDX_SOFTWARE_SMI_COMMAND, 32'ha5);
    hold(3);
    chk("irq", 32'(irq), 32'h0);
    wr(IDX_GBL_CTL, 32'h5);
    hold(3);
    chk("smi_req", 32'(smi_req), 32'h1);
    wr(IDX_GBL_STS, 32'h3);
    hold(3);
    chk("smi_req", 32'(smi_req), 32'h0);
    chk("open_notes", 32'(exp_q.size()), 32'h0);
    wrap_up();
  end
endmodule
